// ### design/charge_seq.v
`timescale 1ns/1ns
`default_nettype none
`include "charger_map.vh"
module charge_seq #(
   parameter integer MS_CYCLES = `CLK_HZ / `MS_PER_S
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // pins
   input wire master_reset_n,
   input wire rate_select_lo,
   input wire rate_select_hi,
   input wire temp_sense_input,
   input wire temp_sense_input_below_hot,
   input wire [9:0] cell_voltage_sense,
   // drives and indicators
   output reg charge_drive,
   output reg discharge_drive,
   output reg charge_mode_indicator_n,
   output reg poll_fault_indicator_n,
   output reg over_temp_indicator_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr
);
   localparam [3:0] ST_PREDIS = 4'h0;
   localparam [3:0] ST_POLL = 4'h1;
   localparam [3:0] ST_SOFT = 4'h2;
   localparam [3:0] ST_FAST = 4'h3;
   localparam [3:0] ST_TOP = 4'h4;
   localparam [3:0] ST_MAINT = 4'h5;
   localparam [3:0] ST_HALT = 4'h6;
   localparam [13:0] MS_LAST = MS_CYCLES[13:0] - 14'h0001;

   reg [3:0] meta_q;
   reg [3:0] sync_q;
   reg [13:0] presc_q;
   reg [9:0] ms_q;
   reg [3:0] state_q;
   reg [1:0] rate_q;
   reg [13:0] stage_s_q;
   reg [13:0] fast_s_q;
   reg [7:0] int_s_q;
   reg [16:0] acc_q;
   reg pfn_q;
   reg otn_q;
   reg flash_q;
   reg restart_q;
   reg [9:0] discharge_drive_ms;
   reg [7:0] top_s;
   reg [7:0] maint_s;
   reg [7:0] ft_min;
   reg chg_d;
   reg discharge_drive_d;
   wire [3:0] pins;
   wire ms_tick;
   wire sec_tick;
   wire held_reset;
   wire seq_hold;
   wire hot;
   wire low_v;
   wire [9:0] chg_end;
   wire [9:0] discharge_drive_end;
   wire [9:0] acq_start;
   wire [10:0] ss_width;
   wire [13:0] ft_limit;
   wire pulse_sec;
   wire acq_last;
   wire term_peak;
   wire term_flat;
   wire apb_rd;
   wire apb_wr;
   wire mapped;

   // every strap and temperature pin passes two flops; the first stage feeds only the second
   assign pins = {temp_sense_input_below_hot, temp_sense_input,
                  rate_select_hi, rate_select_lo};
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_sync
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= pins[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   // millisecond time base from the 10 MHz clock
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         presc_q <= 14'h0000;
      else if (presc_q == MS_LAST)
         presc_q <= 14'h0000;
      else
         presc_q <= presc_q + 14'h0001;
   end
   assign ms_tick = (presc_q == MS_LAST);
   assign sec_tick = ms_tick && (ms_q == `CYCLE_MS);

   mrst_filter u_mrst (
      .mclk(mclk),
      .rst_n(rst_n),
      .master_reset_n(master_reset_n),
      .ms_tick(ms_tick),
      .held_reset(held_reset)
   );
   assign seq_hold = held_reset | restart_q;

   // per-rate tables; the rate is the captured one, never the live pins
   always @* begin
      case (rate_q)
         2'b00: begin
            discharge_drive_ms = `DISCHARGE_DRIVE_MS_R0;
            top_s = `TOP_S_R0;
            maint_s = `MAINT_S_R0;
            ft_min = `FT_MIN_R0;
         end
         2'b01: begin
            discharge_drive_ms = `DISCHARGE_DRIVE_MS_R1;
            top_s = `TOP_S_R1;
            maint_s = `MAINT_S_R1;
            ft_min = `FT_MIN_R1;
         end
         2'b10: begin
            discharge_drive_ms = `DISCHARGE_DRIVE_MS_R2;
            top_s = `TOP_S_R2;
            maint_s = `MAINT_S_R2;
            ft_min = `FT_MIN_R2;
         end
         default: begin
            discharge_drive_ms = `DISCHARGE_DRIVE_MS_R3;
            top_s = `TOP_S_R3;
            maint_s = `MAINT_S_R3;
            ft_min = `FT_MIN_R3;
         end
      endcase
   end

   // cycle layout: charge, discharge, rest, then acquisition to the end
   assign acq_start = `CYCLE_MS + 10'h001 - `ACQ_MS;
   assign discharge_drive_end = acq_start - `REST_MS;
   assign chg_end = discharge_drive_end - discharge_drive_ms;
   assign ft_limit = ft_min * `S_PER_MIN;
   assign ss_width = `SS_START_MS + stage_s_q[10:0] * `SS_STEP_MS;
   assign pulse_sec = (int_s_q == 8'h00);
   assign acq_last = ms_tick && (ms_q == `CYCLE_MS);
   assign hot = sync_q[2] | sync_q[3];
   assign low_v = (cell_voltage_sense < `V_0P5);

   // drive pattern for the current state and millisecond
   always @* begin
      chg_d = 1'b0;
      discharge_drive_d = 1'b0;
      case (state_q)
         ST_PREDIS:
            discharge_drive_d = (ms_q < `PRE_DISCHARGE_DRIVE_SPAN_MS) && !ms_q[3];
         ST_POLL:
            chg_d = (ms_q < `POLL_PULSE_MS);
         ST_SOFT: begin
            // width grows each second; never a discharge here
            chg_d = ({1'b0, ms_q} < ss_width) ||
                    (ss_width >= `SS_FULL_MS);
         end
         ST_FAST: begin
            chg_d = (ms_q < chg_end);
            discharge_drive_d = (ms_q >= chg_end) && (ms_q < discharge_drive_end);
         end
         ST_TOP, ST_MAINT: begin
            chg_d = pulse_sec && (ms_q < chg_end);
            discharge_drive_d = pulse_sec && (ms_q >= chg_end) &&
                     (ms_q < discharge_drive_end);
         end
         default: begin
            chg_d = 1'b0;
            discharge_drive_d = 1'b0;
         end
      endcase
   end

   // sequencer
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_PREDIS;
         ms_q <= 10'h000;
         rate_q <= 2'b00;
         stage_s_q <= 14'h0000;
         fast_s_q <= 14'h0000;
         int_s_q <= 8'h00;
         acc_q <= 17'h00000;
         pfn_q <= 1'b0;
         otn_q <= 1'b0;
         flash_q <= 1'b0;
      end else if (seq_hold) begin
         state_q <= ST_PREDIS;
         ms_q <= 10'h000;
         stage_s_q <= 14'h0000;
         pfn_q <= 1'b0;
         otn_q <= 1'b0;
         flash_q <= 1'b0;
      end else begin
         if (ms_tick)
            ms_q <= (ms_q == `CYCLE_MS) ? 10'h000 : ms_q + 10'h001;
         if (sec_tick)
            flash_q <= ~flash_q;
         // acquisition integrates one reading over the whole window
         if (ms_tick && ms_q == acq_start)
            acq_q_load(cell_voltage_sense);
         else if (ms_tick && ms_q > acq_start)
            acc_q <= acc_q + {7'h00, cell_voltage_sense};
         if (hot && state_q != ST_HALT) begin
            state_q <= ST_HALT;
            otn_q <= 1'b1;
         end else begin
            case (state_q)
               ST_PREDIS: begin
                  // sample the straps only right after a reset
                  rate_q <= {sync_q[0], sync_q[1]};
                  if (ms_tick && ms_q == `PRE_CHECK_MS) begin
                     ms_q <= 10'h000;
                     stage_s_q <= 14'h0000;
                     fast_s_q <= 14'h0000;
                     state_q <= low_v ? ST_POLL : ST_SOFT;
                  end
               end
               ST_POLL: begin
                  if (ms_tick && ms_q == `POLL_PULSE_MS - 10'h001) begin
                     if (cell_voltage_sense < `V_2P0) begin
                        pfn_q <= 1'b0;
                        ms_q <= 10'h000;
                        stage_s_q <= 14'h0000;
                        fast_s_q <= 14'h0000;
                        state_q <= ST_SOFT;
                     end else begin
                        pfn_q <= 1'b1;
                     end
                  end else if (sec_tick) begin
                     stage_s_q <= stage_s_q + 14'h0001;
                     if (stage_s_q == `POLL_WINDOW_S - 14'h0001)
                        state_q <= ST_HALT;
                  end
               end
               ST_SOFT: begin
                  if (sec_tick) begin
                     stage_s_q <= stage_s_q + 14'h0001;
                     fast_s_q <= fast_s_q + 14'h0001;
                     if (stage_s_q == `SS_SPAN_S - 14'h0001)
                        state_q <= ST_FAST;
                  end
               end
               ST_FAST: begin
                  if (sec_tick)
                     fast_s_q <= fast_s_q + 14'h0001;
                  if (ms_tick && !chg_d && !discharge_drive_d && low_v) begin
                     state_q <= ST_HALT;
                     pfn_q <= 1'b1;
                  end else if (term_peak || term_flat ||
                               fast_s_q >= ft_limit) begin
                     state_q <= ST_TOP;
                     stage_s_q <= 14'h0000;
                     int_s_q <= 8'h00;
                     ms_q <= 10'h000;
                  end
               end
               ST_TOP, ST_MAINT: begin
                  if (ms_tick && !chg_d && !discharge_drive_d && low_v) begin
                     state_q <= ST_HALT;
                     pfn_q <= 1'b1;
                  end else if (sec_tick) begin
                     stage_s_q <= stage_s_q + 14'h0001;
                     if (state_q == ST_TOP &&
                         stage_s_q == `TOP_SPAN_S - 14'h0001) begin
                        state_q <= ST_MAINT;
                        int_s_q <= 8'h00;
                     end else if (int_s_q == ((state_q == ST_TOP) ?
                                  top_s : maint_s) - 8'h01) begin
                        int_s_q <= 8'h00;
                     end else begin
                        int_s_q <= int_s_q + 8'h01;
                     end
                  end
               end
               ST_HALT: begin
                  state_q <= ST_HALT;
               end
               default: begin
                  state_q <= ST_HALT;
               end
            endcase
         end
      end
   end

   // loading the first acquisition sample restarts the running sum
   task acq_q_load;
      input [9:0] v;
      begin
         acc_q <= {7'h00, v};
      end
   endtask

   slope_detect u_slope (
      .mclk(mclk),
      .rst_n(rst_n),
      .clear(state_q != ST_FAST),
      .sample_valid(state_q == ST_FAST && acq_last),
      .sample(acc_q + {7'h00, cell_voltage_sense}),
      .term_peak(term_peak),
      .term_flat(term_flat)
   );

   // registered pins; one cycle behind the sequencer, glitch free
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         charge_drive <= 1'b0;
         discharge_drive <= 1'b0;
         charge_mode_indicator_n <= 1'b1;
         poll_fault_indicator_n <= 1'b1;
         over_temp_indicator_n <= 1'b1;
      end else begin
         charge_drive <= chg_d & ~seq_hold & ~hot;
         discharge_drive <= discharge_drive_d & ~seq_hold & ~hot;
         if (state_q == ST_SOFT || state_q == ST_FAST)
            charge_mode_indicator_n <= 1'b0;
         else if (state_q == ST_TOP || state_q == ST_MAINT)
            charge_mode_indicator_n <= flash_q;
         else
            charge_mode_indicator_n <= 1'b1;
         poll_fault_indicator_n <= ~pfn_q;
         over_temp_indicator_n <= ~otn_q;
      end
   end

   // apb slave: zero wait states, unmapped addresses flag an error
   assign mapped = (paddr == `CTRL_ADDR) || (paddr == `STAT_ADDR);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign apb_rd = psel & ~penable & ~pwrite;
   assign apb_wr = psel & penable & pwrite & mapped;

   // a software restart replays the whole power-up sequence
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         restart_q <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         restart_q <= apb_wr && (paddr == `CTRL_ADDR) &&
                      pwdata[`CTRL_RESTART_BIT];
         if (apb_rd) begin
            if (paddr == `STAT_ADDR)
               prdata <= {2'b00, fast_s_q, 7'h00, flash_q, rate_q,
                          otn_q, pfn_q, state_q};
            else
               prdata <= 32'h00000000;
         end
      end
   end
endmodule
`default_nettype wire

// ### design/charger_map.vh
`ifndef CHARGER_MAP_VH
`define CHARGER_MAP_VH
// clock and time base
`define CLK_HZ 10000000
`define MS_PER_S 1000
`define CYCLE_MS 10'h3E7
// master reset filter
`define MRST_MS 10'h2BC
// power-up discharge series, then presence check
`define PRE_DISCHARGE_DRIVE_SPAN_MS 10'h040
`define PRE_CHECK_MS 10'h064
// polling
`define POLL_PULSE_MS 10'h064
`define POLL_WINDOW_S 14'h000A
// soft start
`define SS_START_MS 10'h0C8
`define SS_FULL_MS 11'h3E8
`define SS_STEP_MS 4'h7
`define SS_SPAN_S 14'h0078
// fast charge cycle layout
`define ACQ_MS 10'h064
`define REST_MS 10'h014
`define DISCHARGE_DRIVE_MS_R0 10'h008
`define DISCHARGE_DRIVE_MS_R1 10'h004
`define DISCHARGE_DRIVE_MS_R2 10'h002
`define DISCHARGE_DRIVE_MS_R3 10'h001
// topping and maintenance pulse intervals in seconds
`define TOP_SPAN_S 14'h1C20
`define TOP_S_R0 8'h28
`define TOP_S_R1 8'h14
`define TOP_S_R2 8'h0A
`define TOP_S_R3 8'h05
`define MAINT_S_R0 8'hA0
`define MAINT_S_R1 8'h50
`define MAINT_S_R2 8'h28
`define MAINT_S_R3 8'h14
// fast charge timer limits in minutes
`define FT_MIN_R0 8'h1E
`define FT_MIN_R1 8'h3C
`define FT_MIN_R2 8'h5A
`define FT_MIN_R3 8'hD2
`define S_PER_MIN 6'h3C
// voltage codes of the converter, 10 bits over 5 V
`define V_0P5 10'h066
`define V_2P0 10'h199
// slope detection
`define SLOPE_MIN_SAMPLES 6'h08
`define FLAT_RUN 3'h3
// register map
`define CTRL_ADDR 12'h000
`define STAT_ADDR 12'h004
`define CTRL_RESTART_BIT 0
`endif

// ### design/mrst_filter.v
`timescale 1ns/1ns
`default_nettype none
`include "charger_map.vh"
module mrst_filter (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // pin and time base
   input wire master_reset_n,
   input wire ms_tick,
   // filtered hold
   output reg held_reset
);
   reg meta_q;
   reg sync_q;
   reg [9:0] low_ms_q;

   // two flops before anything looks at the pin
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= master_reset_n;
         sync_q <= meta_q;
      end
   end

   // short glitches never restart the sequence; hold lasts while low
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         low_ms_q <= 10'h000;
         held_reset <= 1'b0;
      end else if (sync_q) begin
         low_ms_q <= 10'h000;
         held_reset <= 1'b0;
      end else if (ms_tick && !held_reset) begin
         if (low_ms_q == `MRST_MS)
            held_reset <= 1'b1;
         else
            low_ms_q <= low_ms_q + 10'h001;
      end
   end
endmodule
`default_nettype wire

// ### design/slope_detect.v
`timescale 1ns/1ns
`default_nettype none
`include "charger_map.vh"
module slope_detect (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // sample stream
   input wire clear,
   input wire sample_valid,
   input wire [16:0] sample,
   // termination flags
   output reg term_peak,
   output reg term_flat
);
   reg [16:0] prev_q;
   reg [5:0] n_q;
   reg signed [17:0] max_q;
   reg [2:0] flat_q;
   wire signed [17:0] slope;
   wire ready;

   assign slope = $signed({1'b0, sample}) - $signed({1'b0, prev_q});
   // the first samples follow the soft start and are not trusted
   assign ready = (n_q >= `SLOPE_MIN_SAMPLES);

   // first derivative tracking, peak of slope and flattening run
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 17'h00000;
         n_q <= 6'h00;
         max_q <= 18'h00000;
         flat_q <= 3'h0;
         term_peak <= 1'b0;
         term_flat <= 1'b0;
      end else if (clear) begin
         n_q <= 6'h00;
         max_q <= 18'h00000;
         flat_q <= 3'h0;
         term_peak <= 1'b0;
         term_flat <= 1'b0;
      end else if (sample_valid) begin
         prev_q <= sample;
         if (!ready)
            n_q <= n_q + 6'h01;
         if (ready && slope > max_q)
            max_q <= slope;
         // slope fell to half its maximum: inflection passed
         if (ready && max_q > 0 && slope < (max_q >>> 1))
            term_peak <= 1'b1;
         if (ready && slope <= 0) begin
            flat_q <= flat_q + 3'h1;
            if (flat_q == `FLAT_RUN - 3'h1)
               term_flat <= 1'b1;
         end else begin
            flat_q <= 3'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ### verification/battery_charge_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module battery_charge_sequencer_test;
   localparam integer MS = 2;
   logic mclk, rst_n, master_reset_n, rate_select_lo, rate_select_hi;
   logic temp_sense_input, temp_sense_input_below_hot, present, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic err;
   wire [9:0] cell_voltage_sense;
   wire charge_drive, discharge_drive, pready, pslverr;
   wire charge_mode_indicator_n, poll_fault_indicator_n;
   wire over_temp_indicator_n;
   wire [31:0] prdata;
   int miscompares, check_count, cyc, n0;
   int chg_run, chg_w, chg_n, discharge_drive_run, discharge_drive_w, discharge_drive_n;
   charge_seq #(.MS_CYCLES(MS)) u_dut (.mclk(mclk), .rst_n(rst_n),
      .master_reset_n(master_reset_n), .rate_select_lo(rate_select_lo),
      .rate_select_hi(rate_select_hi), .temp_sense_input(temp_sense_input),
      .temp_sense_input_below_hot(temp_sense_input_below_hot),
      .cell_voltage_sense(cell_voltage_sense), .charge_drive(charge_drive),
      .discharge_drive(discharge_drive),
      .charge_mode_indicator_n(charge_mode_indicator_n),
      .poll_fault_indicator_n(poll_fault_indicator_n),
      .over_temp_indicator_n(over_temp_indicator_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   battery_model u_bat (.charge_drive(charge_drive), .present(present),
      .cell_voltage_sense(cell_voltage_sense));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // pulse widths in clocks and pulse counts, taken at each rising edge
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (charge_drive === 1'b1) begin
         chg_run <= chg_run + 1;
      end else if (chg_run != 0) begin
         chg_w <= chg_run;
         chg_n <= chg_n + 1;
         chg_run <= 0;
      end
      if (discharge_drive === 1'b1) begin
         discharge_drive_run <= discharge_drive_run + 1;
      end else if (discharge_drive_run != 0) begin
         discharge_drive_w <= discharge_drive_run;
         discharge_drive_n <= discharge_drive_n + 1;
         discharge_drive_run <= 0;
      end
   end
   // a hang counts as a mismatch and ends the run
   always @(posedge mclk) begin
      if (cyc == 60000) begin
         miscompares++;
         end_of_test;
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   // widths are compared with a 2 ms margin for sync and tick phase
   function logic [31:0] near(input int w, input int ms);
      near = (w >= (ms - 2) * MS) && (w <= (ms + 2) * MS);
   endfunction
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task ms_wait(input int n);
      repeat (n * MS) @(posedge mclk);
   endtask
   task wait_chg(input int n);
      while (chg_n < n) @(posedge mclk);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = 0;
      {temp_sense_input_below_hot, present, rate_select_hi} = 0;
      temp_sense_input = 1'b0;
      master_reset_n = 1'b1;
      rate_select_lo = 1'b1;
      rst_n = 1'b0;
      repeat (12) @(posedge mclk);
      check({charge_drive, discharge_drive}, 32'h0);
      check({charge_mode_indicator_n, poll_fault_indicator_n,
         over_temp_indicator_n}, 32'h7);
      rst_n <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      check({err, rd[30:0]}, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      check({err, rd[30:0]}, 32'h80000000);
      apb(1'b1, 12'h00C, 32'hFFFFFFFF);
      check(err, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      check(rd[7:6], 32'h2);
      $display("test registers done");
      // no battery: discharge series, then polling pulses
      ms_wait(95);
      check(discharge_drive_n, 32'h4);
      check(near(discharge_drive_w, 8), 32'h1);
      check(chg_n, 32'h0);
      wait_chg(1);
      check(near(chg_w, 100), 32'h1);
      check(poll_fault_indicator_n, 32'h0);
      wait_chg(2);
      check(near(chg_w, 100), 32'h1);
      present <= 1'b1;
      while (poll_fault_indicator_n !== 1'b1) @(posedge mclk);
      ms_wait(1);
      check(charge_mode_indicator_n, 32'h0);
      n0 = chg_n;
      wait_chg(n0 + 2);
      check(near(chg_w, 207), 32'h1);
      check(discharge_drive_n, 32'h4);
      check(charge_mode_indicator_n, 32'h0);
      // rate pins moved after capture are ignored
      rate_select_lo <= 1'b0;
      rate_select_hi <= 1'b1;
      ms_wait(5);
      apb(1'b0, 12'h004, 32'h0);
      check(rd[7:6], 32'h2);
      $display("test polling and soft start done");
      temp_sense_input <= 1'b1;
      ms_wait(2);
      temp_sense_input <= 1'b0;
      ms_wait(2);
      check({over_temp_indicator_n, charge_drive}, 32'h0);
      n0 = chg_n;
      ms_wait(1500);
      check(chg_n, n0);
      check(over_temp_indicator_n, 32'h0);
      // a short master reset pulse must not clear the fault
      master_reset_n <= 1'b0;
      ms_wait(300);
      master_reset_n <= 1'b1;
      ms_wait(5);
      check(over_temp_indicator_n, 32'h0);
      n0 = discharge_drive_n;
      master_reset_n <= 1'b0;
      ms_wait(750);
      check({over_temp_indicator_n, charge_drive}, 32'h2);
      master_reset_n <= 1'b1;
      ms_wait(120);
      check(discharge_drive_n, n0 + 4);
      check(charge_mode_indicator_n, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check(rd[7:6], 32'h1);
      $display("test hot switch and master reset done");
      temp_sense_input_below_hot <= 1'b1;
      ms_wait(2);
      temp_sense_input_below_hot <= 1'b0;
      ms_wait(2);
      check({over_temp_indicator_n, charge_drive}, 32'h0);
      // battery gone: ten seconds of polling, then halt
      present <= 1'b0;
      master_reset_n <= 1'b0;
      ms_wait(720);
      n0 = chg_n;
      master_reset_n <= 1'b1;
      ms_wait(10400);
      check(poll_fault_indicator_n, 32'h0);
      check((chg_n - n0 >= 9) && (chg_n - n0 <= 11), 32'h1);
      n0 = chg_n;
      ms_wait(2000);
      check(chg_n, n0);
      apb(1'b0, 12'h004, 32'h0);
      check(rd[5:0], 32'h16);
      // a software restart leaves the halt like a held master reset
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      check({poll_fault_indicator_n, rd[5:0]}, 32'h40);
      $display("test thermistor and poll halt done");
      end_of_test;
   end
endmodule
`default_nettype wire

// ### verification/battery_model.sv
`timescale 1ns/1ns
`default_nettype none
module battery_model (
   // drive from the sequencer
   input wire logic charge_drive,
   // battery fitted at the terminals
   input wire logic present,
   // divided cell voltage as a converter code
   output logic [9:0] cell_voltage_sense
);
   // a fitted cell clamps near 1.2 V; open terminals float high under
   // charge and bleed to zero otherwise, as the discharge path drains them
   assign cell_voltage_sense = present ? 10'h0F6 :
      (charge_drive ? 10'h3FF : 10'h000);
endmodule
`default_nettype wire

// ### verification/charge_seq_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module charge_seq_monitor #(
   parameter integer MS_CYCLES = 10000
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // pins
   input wire master_reset_n,
   input wire rate_select_lo,
   input wire rate_select_hi,
   input wire temp_sense_input,
   input wire temp_sense_input_below_hot,
   input wire [9:0] cell_voltage_sense,
   // drives and indicators
   input wire charge_drive,
   input wire discharge_drive,
   input wire charge_mode_indicator_n,
   input wire poll_fault_indicator_n,
   input wire over_temp_indicator_n,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   localparam int DISCHARGE_DRIVE_LIM = 8 * MS_CYCLES + 1;
   localparam int MRST_LIM = 701 * MS_CYCLES + 8;
   int discharge_drive_run_q;
   int mrn_low_q;
   wire mapped = (paddr == 12'h000) || (paddr == 12'h004);
   // run lengths; the hold counter allows for the pin synchroniser
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         discharge_drive_run_q <= 0;
         mrn_low_q <= 0;
      end else begin
         discharge_drive_run_q <= discharge_drive ? discharge_drive_run_q + 1 : 0;
         mrn_low_q <= master_reset_n ? 0 : mrn_low_q + 1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_drive_overlap: assert property (
      !(charge_drive && discharge_drive))
      else $error("charge and discharge drives high together");
   chk_hot_switch: assert property (
      $rose(temp_sense_input) && poll_fault_indicator_n && master_reset_n
      |-> ##[1:8] (!over_temp_indicator_n && !charge_drive))
      else $error("open thermal switch did not shut down");
   chk_hot_temp_sense_input: assert property (
      $rose(temp_sense_input_below_hot) && poll_fault_indicator_n && master_reset_n
      |-> ##[1:8] (!over_temp_indicator_n && !charge_drive))
      else $error("hot thermistor did not shut down");
   chk_hot_sticky: assert property (
      !over_temp_indicator_n && master_reset_n && !psel &&
      !$past(psel) && !$past(psel, 2)
      |=> !over_temp_indicator_n)
      else $error("temperature fault cleared without reset");
   chk_shutdown_quiet: assert property (
      !over_temp_indicator_n |=> !charge_drive && !discharge_drive)
      else $error("drive active during temperature shutdown");
   chk_discharge_drive_width: assert property (
      discharge_drive_run_q <= DISCHARGE_DRIVE_LIM)
      else $error("discharge pulse too long");
   chk_mrst_hold: assert property (
      mrn_low_q > MRST_LIM |-> !charge_drive && !discharge_drive
      && poll_fault_indicator_n && over_temp_indicator_n)
      else $error("held master reset did not reset");
   chk_unmapped_err: assert property (
      psel && penable |-> pslverr == !mapped)
      else $error("error response wrong for address");
   chk_ctrl_reads_zero: assert property (
      psel && penable && !pwrite && paddr == 12'h000 |-> prdata == 0)
      else $error("control word read not zero");
   cover property ($fell(over_temp_indicator_n));
   cover property ($rose(discharge_drive));
   cover property (psel && penable && pslverr);
   cover property ($rose(poll_fault_indicator_n));
endmodule
bind charge_seq charge_seq_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
   .mclk(mclk), .rst_n(rst_n), .master_reset_n(master_reset_n),
   .rate_select_lo(rate_select_lo), .rate_select_hi(rate_select_hi),
   .temp_sense_input(temp_sense_input), .temp_sense_input_below_hot(temp_sense_input_below_hot),
   .cell_voltage_sense(cell_voltage_sense), .charge_drive(charge_drive),
   .discharge_drive(discharge_drive),
   .charge_mode_indicator_n(charge_mode_indicator_n),
   .poll_fault_indicator_n(poll_fault_indicator_n),
   .over_temp_indicator_n(over_temp_indicator_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
